// [tae_core_model.sv]
// behavioural core pipeline handing retirement reports to the generator
`timescale 1ns/1ps
module tae_core_model (
   input  wire logic            CLK,
   input  wire logic            IN_READY,
   output logic                 IN_VALID,
   output tae_pkg::tae_retire_t IN_REC
);
   import tae_pkg::*;
   initial begin
      IN_VALID = 1'b0;
      IN_REC   = '0;
   end
   // hold each report until taken or for at most 201 cycles; idle lines show the inverted pattern
   task automatic run(input tae_retire_t q[$], input int gap);
      foreach (q[i]) begin
         IN_VALID <= 1'b1;
         IN_REC   <= q[i];
         @(posedge CLK);
         for (int k = 0; k < 200 && !IN_READY; k++) @(posedge CLK);
         if (gap > 0 || i == q.size() - 1) begin
            IN_VALID <= 1'b0;
            IN_REC   <= ~q[i];
            repeat (gap + 1) @(posedge CLK);
         end
      end
   endtask : run
endmodule : tae_core_model

// [tae_gen.sv]
// trace atom and exception element generator with its output element fifo
//
// Operation
// R1: taken branch gives E atom or source address
// R2: not taken gives N atom or nothing
// R3: once omitted, keep omitting until taken/exception
// R4: exception during omission gives exception element
// R5: taken after omission gives source address element
// R6: mispredicted omitted instruction gives source address
// R7: atoms leave strictly in program order
// R8: unconditional N atom later gets mispredict correction
// R9: failing barrier without sync is not taken
// R10: failing barrier with sync is taken
// R11: passing barrier is always taken
// R12: wait instructions optionally branch class, give atoms
// R13: passing conditional wait gives E atom
// R14: failing nop branch gives N atom
// R15: failing undefined branch gives exception, no atom
// R16: every atom is marked speculative
// R17: traced exceptional occurrence gives exception element
// R18: exception elements kept in program order
// R19: target address before exception in three cases
// R20: context element before exception on context change
// R21: invalid fetch address returned in full
// R22: source address is taken instruction address
// R23: omission state cleared on reset and restart
`timescale 1ns/1ps

// ----------------------------------------------------------------
// synchronous fifo
// ----------------------------------------------------------------
module tae_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              do_wr;
   wire              do_rd;
   wire              full;
   wire              empty;

   // full and empty come straight from the word count
   assign full      = (count == (AW+1)'(DEPTH));
   assign empty     = (count == '0);
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------

   // storage array, no reset needed
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // ----------------------------------------------------------------
   // occupancy
   // ----------------------------------------------------------------

   // pointers and occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (do_rd) begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         unique case ({do_wr, do_rd})
            2'b10:   count <= (AW+1)'(count + 1'b1);
            2'b01:   count <= (AW+1)'(count - 1'b1);
            default: count <= count;
         endcase
      end
   end
endmodule : tae_fifo

// ----------------------------------------------------------------
// element generator top
// ----------------------------------------------------------------
module tae_gen
   import tae_pkg::*;
#(
   parameter int   VA_BITS        = tae_pkg::VA_BITS_DFLT,
   parameter logic WAIT_IS_BRANCH = 1'b1,
   parameter int   DEPTH          = tae_pkg::FIFO_DEPTH
) (
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                IN_VALID,
   output logic                     IN_READY,
   input  wire tae_pkg::tae_retire_t IN_REC,
   input  wire logic                SUPPRESS_EN,
   input  wire logic                TRACE_RESTART,
   output logic                     WAIT_CLASS_MODE,
   output logic                     OUT_VALID,
   input  wire logic                OUT_READY,
   output tae_pkg::tae_elem_t       OUT_ELEM
);
   import tae_pkg::*;

   typedef enum {
      ST_IDLE,
      ST_TGT,
      ST_CTX,
      ST_EXC
   } tae_state_t;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // upper address bits not all equal means invalid
   function automatic logic addr_invalid(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] hi;
      logic [ADDR_W-1:0] ones;
      hi           = a >> VA_BITS;
      ones         = {ADDR_W{1'b1}} >> VA_BITS;
      addr_invalid = (hi != '0) && (hi != ones);
   endfunction : addr_invalid

   // build one element
   function automatic tae_elem_t mk_elem(input tae_elem_kind_t k,
                                         input logic [ADDR_W-1:0] a,
                                         input logic [CTX_W-1:0] c);
      tae_elem_t e;
      e.kind    = k;
      e.spec    = (k == EL_ATOM_E) || (k == EL_ATOM_N);   // R16
      e.invalid = addr_invalid(a);
      e.addr    = a;
      e.ctx     = c;
      mk_elem   = e;
   endfunction : mk_elem

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tae_state_t        state;
   tae_state_t        next_state;
   logic              suppress;        // N atoms being omitted
   logic              next_suppress;
   logic              last_tgt;        // next exception needs target address
   logic              next_last_tgt;
   logic [ADDR_W-1:0] h_addr;          // held exception origin
   logic [ADDR_W-1:0] h_ret;           // held return address
   logic [CTX_W-1:0]  h_ctx;           // held context
   logic              h_ctx_need;      // held context change flag

   // ----------------------------------------------------------------
   // classification of the incoming report
   // ----------------------------------------------------------------
   wire is_branch = (IN_REC.kind == IK_BRANCH);
   wire is_isb    = (IN_REC.kind == IK_SYNC_BARRIER);
   wire is_wait   = (IN_REC.kind == IK_WAIT) & WAIT_IS_BRANCH;   // R12
   wire is_p0     = is_branch | is_isb | is_wait;
   wire c_fail    = IN_REC.cond & (~IN_REC.cond_pass | IN_REC.pred_fail);
   wire isb_tkn   = ~IN_REC.cond | IN_REC.cond_pass | IN_REC.ctx_sync;   // R9 R10 R11
   wire wait_tkn  = ~IN_REC.cond | IN_REC.cond_pass;   // R13
   wire br_tkn    = IN_REC.taken & ~c_fail;   // R14
   wire undef_f   = is_branch & c_fail & IN_REC.undef;   // R15
   wire exc_path  = IN_REC.exc | undef_f;   // R17
   wire taken     = is_isb ? isb_tkn : (is_wait ? wait_tkn : br_tkn);
   wire omit_n    = ~taken & (suppress | SUPPRESS_EN);   // R2 R3
   wire [ADDR_W-1:0] ret_a = undef_f ? IN_REC.addr : IN_REC.ret_addr;   // R15 R21

   // ----------------------------------------------------------------
   // direct elements
   // ----------------------------------------------------------------

   // direct element for non exception reports
   wire direct_emit = IN_REC.misp | (is_p0 & (taken | ~omit_n));
   wire tae_elem_kind_t direct_kind =
        IN_REC.misp ? (suppress ? EL_SRC_ADDR : EL_MISPREDICT) :   // R6 R8
        taken       ? (suppress ? EL_SRC_ADDR : EL_ATOM_E)     :   // R1 R5
                      EL_ATOM_N;   // R2 R14

   // exception sequence needs
   wire need_tgt = last_tgt & ~IN_REC.rs_match;   // R19
   wire need_ctx = IN_REC.ctx_change;   // R20

   // ----------------------------------------------------------------
   // fifo write side
   // ----------------------------------------------------------------
   wire       idle      = (state == ST_IDLE);
   wire       fifo_rdy;
   wire       push_v;
   tae_elem_t push_e;

   // one element per cycle keeps program order
   assign push_v = idle ? (IN_VALID & direct_emit & ~exc_path) : 1'b1;   // R7 R18
   assign IN_READY = idle & (fifo_rdy | exc_path | ~direct_emit);

   wire accept = IN_VALID & IN_READY;

   // element selection by sequence step
   always_comb begin
      unique case (state)
         ST_IDLE: push_e = mk_elem(direct_kind, IN_REC.addr, '0);   // R22
         ST_TGT:  push_e = mk_elem(EL_TGT_ADDR, h_addr, '0);   // R19
         ST_CTX:  push_e = mk_elem(EL_CONTEXT, h_addr, h_ctx);   // R20
         ST_EXC:  push_e = mk_elem(EL_EXCEPTION, h_ret, '0);   // R4 R17 R21
      endcase
   end

   // ----------------------------------------------------------------
   // sequence control
   // ----------------------------------------------------------------
   wire step = fifo_rdy;

   // next state of the exception sequence
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (accept && exc_path) begin
               next_state = need_tgt ? ST_TGT : (need_ctx ? ST_CTX : ST_EXC);
            end
         end
         ST_TGT: begin
            if (step) begin
               next_state = h_ctx_need ? ST_CTX : ST_EXC;
            end
         end
         ST_CTX: begin
            if (step) begin
               next_state = ST_EXC;
            end
         end
         ST_EXC: begin
            if (step) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // omission tracking
   // ----------------------------------------------------------------

   // omission and pending target tracking
   always_comb begin
      next_suppress = suppress;
      next_last_tgt = last_tgt;
      if (accept) begin
         if (exc_path) begin
            next_suppress = 1'b0;   // R3 R4
            next_last_tgt = 1'b1;   // R19
         end else if (IN_REC.misp) begin
            next_suppress = 1'b0;   // R6
         end else if (is_p0 && taken) begin
            next_suppress = 1'b0;   // R3 R5
            next_last_tgt = IN_REC.indirect | IN_REC.broadcast;   // R19
         end else if (is_p0) begin
            next_suppress = omit_n;   // R3
            next_last_tgt = 1'b0;
         end
      end
      if (TRACE_RESTART) begin
         next_suppress = SUPPRESS_RST;   // R23
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------

   // state registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state    <= ST_IDLE;
         suppress <= SUPPRESS_RST;   // R23
         last_tgt <= LAST_TGT_RST;
      end else begin
         state    <= next_state;
         suppress <= next_suppress;
         last_tgt <= next_last_tgt;
      end
   end

   // ----------------------------------------------------------------
   // exception capture
   // ----------------------------------------------------------------

   // held exception details
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         h_addr     <= '0;
         h_ret      <= '0;
         h_ctx      <= '0;
         h_ctx_need <= 1'b0;
      end else if (accept && exc_path) begin
         h_addr     <= IN_REC.addr;
         h_ret      <= ret_a;
         h_ctx      <= IN_REC.ctx;
         h_ctx_need <= need_ctx;
      end
   end

   // ----------------------------------------------------------------
   // output element buffer
   // ----------------------------------------------------------------
   tae_fifo #(
      .WIDTH ($bits(tae_elem_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst_n     (RST_N),
      .in_valid  (push_v),
      .in_ready  (fifo_rdy),
      .in_data   (push_e),
      .out_valid (OUT_VALID),
      .out_ready (OUT_READY),
      .out_data  (OUT_ELEM)
   );

   // ----------------------------------------------------------------
   // identification
   // ----------------------------------------------------------------

   // wait class choice reported outward
   assign WAIT_CLASS_MODE = WAIT_IS_BRANCH;   // R12

endmodule : tae_gen

// [tae_gen_monitor.sv]
// concurrent checks on the trace element generator ports
`timescale 1ns/1ps
module tae_gen_monitor #(
   parameter int   VA_BITS        = 48,
   parameter logic WAIT_IS_BRANCH = 1'b1,
   parameter int   DEPTH          = 32
) (
   input wire logic                 CLK,
   input wire logic                 RST_N,
   input wire logic                 IN_VALID,
   input wire logic                 IN_READY,
   input wire tae_pkg::tae_retire_t IN_REC,
   input wire logic                 SUPPRESS_EN,
   input wire logic                 TRACE_RESTART,
   input wire logic                 WAIT_CLASS_MODE,
   input wire logic                 OUT_VALID,
   input wire logic                 OUT_READY,
   input wire tae_pkg::tae_elem_t   OUT_ELEM
);
   import tae_pkg::*;
   // accepted report classes, taken only with an empty buffer
   wire acc  = IN_VALID && IN_READY;
   wire base = acc && IN_REC.kind == IK_BRANCH && !IN_REC.exc && !IN_REC.misp && !OUT_VALID;
   wire br   = base && !IN_REC.undef;
   wire und  = base && IN_REC.undef && IN_REC.cond && !IN_REC.cond_pass;
   wire atom = OUT_ELEM.kind inside {EL_ATOM_E, EL_ATOM_N};
   // address with its upper bits made uniform
   wire [ADDR_W-1:0] sext = {{(ADDR_W-VA_BITS-1){OUT_ELEM.addr[VA_BITS]}},
                             OUT_ELEM.addr[VA_BITS:0]};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // exception accepted into an empty buffer, then three cycles with OUT_READY high
   sequence exc_drain;
      acc && IN_REC.exc && !OUT_VALID ##1 OUT_READY [*3];
   endsequence
   a_taken_elem: assert property (
      br && IN_REC.taken && !IN_REC.pred_fail && (IN_REC.cond_pass || !IN_REC.cond)
      |=> OUT_VALID && OUT_ELEM.kind inside {EL_ATOM_E, EL_SRC_ADDR}
      && OUT_ELEM.addr == $past(IN_REC.addr)) else $error("taken element wrong");
   a_nop_fail: assert property (
      br && IN_REC.cond && !IN_REC.cond_pass && !IN_REC.taken
      |=> !OUT_VALID || OUT_ELEM.kind == EL_ATOM_N) else $error("failing branch not N");
   a_omit_none: assert property (
      br && SUPPRESS_EN && !TRACE_RESTART && !IN_REC.taken |=> !OUT_VALID)
      else $error("omitted atom emitted");
   a_undef_exc: assert property (
      und |=> ##1 OUT_VALID && !atom) else $error("undefined branch gave atom");
   a_atom_spec: assert property (
      OUT_VALID && atom |-> OUT_ELEM.spec) else $error("atom not speculative");
   a_head_hold: assert property (
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_ELEM)) else $error("head lost");
   a_exc_blocks: assert property (
      acc && IN_REC.exc |=> !IN_READY) else $error("report taken inside exception");
   a_exc_done: assert property (
      exc_drain |=> IN_READY) else $error("exception sequence too long");
   a_invalid_flag: assert property (
      OUT_VALID && OUT_ELEM.kind == EL_EXCEPTION |-> OUT_ELEM.invalid == (OUT_ELEM.addr != sext))
      else $error("invalid flag wrong");
   a_wait_mode: assert property (
      WAIT_CLASS_MODE == WAIT_IS_BRANCH) else $error("wait class mode wrong");
endmodule : tae_gen_monitor

bind tae_gen tae_gen_monitor #(.VA_BITS(VA_BITS), .WAIT_IS_BRANCH(WAIT_IS_BRANCH), .DEPTH(DEPTH))
   i_mon (.CLK, .RST_N, .IN_VALID, .IN_READY, .IN_REC, .SUPPRESS_EN, .TRACE_RESTART,
   .WAIT_CLASS_MODE, .OUT_VALID, .OUT_READY, .OUT_ELEM);

// [tae_pkg.sv]
// types and constants shared by the trace atom and exception element generator
package tae_pkg;

   // ----------------------------------------------------------------
   // sizes and values after reset
   // ----------------------------------------------------------------
   localparam int         FIFO_DEPTH    = 32;     // element buffer depth
   localparam int         ADDR_W        = 64;     // virtual address width
   localparam int         CTX_W         = 32;     // context word width
   localparam int         VA_BITS_DFLT  = 48;     // default maximum virtual address size
   localparam logic       SUPPRESS_RST  = 1'b0;   // normal atom mode after reset
   localparam logic       LAST_TGT_RST  = 1'b0;   // no target address pending after reset

   // ----------------------------------------------------------------
   // retired instruction classes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      IK_OTHER,
      IK_BRANCH,
      IK_SYNC_BARRIER,
      IK_WAIT
   } tae_insn_kind_t;

   // ----------------------------------------------------------------
   // trace element kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EL_ATOM_E,
      EL_ATOM_N,
      EL_SRC_ADDR,
      EL_TGT_ADDR,
      EL_CONTEXT,
      EL_EXCEPTION,
      EL_MISPREDICT
   } tae_elem_kind_t;

   // ----------------------------------------------------------------
   // one report from the core pipeline
   // ----------------------------------------------------------------
   typedef struct packed {
      tae_insn_kind_t     kind;        // instruction class
      logic               cond;        // instruction is conditional
      logic               cond_pass;   // condition check passed
      logic               pred_fail;   // predicted to fail its condition
      logic               taken;       // branch taken
      logic               ctx_sync;    // barrier performed context synchronization
      logic               indirect;    // indirect branch
      logic               broadcast;   // direct branch in a broadcast region
      logic               undef;       // failing instruction raises undefined exception
      logic               exc;         // exceptional occurrence
      logic               rs_match;    // return stack match drops the target address
      logic               ctx_change;  // context changed at preceding target
      logic               misp;        // earlier not taken instruction was mispredicted
      logic [ADDR_W-1:0]  addr;        // instruction virtual address
      logic [ADDR_W-1:0]  ret_addr;    // preferred exception return address
      logic [CTX_W-1:0]   ctx;         // originating context
   } tae_retire_t;

   // ----------------------------------------------------------------
   // one trace element
   // ----------------------------------------------------------------
   typedef struct packed {
      tae_elem_kind_t     kind;        // element kind
      logic               spec;        // element is speculative
      logic               invalid;     // carried address is invalid
      logic [ADDR_W-1:0]  addr;        // carried address
      logic [CTX_W-1:0]   ctx;         // context for context elements
   } tae_elem_t;

endpackage : tae_pkg

// [tb_top.sv]
// self-checking bench for the trace element generator
`timescale 1ns/1ps
module tb_top;
   import tae_pkg::*;
   logic        CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        SUPPRESS_EN = 1'b0;
   logic        TRACE_RESTART = 1'b0;
   logic        OUT_READY = 1'b0;
   logic        hold = 1'b0;
   logic        slow = 1'b0;
   logic        IN_VALID;
   logic        IN_READY;
   logic        WAIT_CLASS_MODE;
   logic        OUT_VALID;
   tae_retire_t IN_REC;
   tae_elem_t   OUT_ELEM;
   tae_elem_t   got[$];
   int          n_errors = 0;
   int          num_checks = 0;

   always #50 CLK = ~CLK;

   tae_gen i_dut (.CLK, .RST_N, .IN_VALID, .IN_READY, .IN_REC, .SUPPRESS_EN, .TRACE_RESTART,
      .WAIT_CLASS_MODE, .OUT_VALID, .OUT_READY, .OUT_ELEM);
   tae_core_model i_core (.CLK, .IN_READY, .IN_VALID, .IN_REC);

   // consumer: fast, every other cycle, or held off; logs popped elements
   always @(posedge CLK) begin
      OUT_READY <= !hold && (!slow || !OUT_READY);
      if (OUT_VALID && OUT_READY) got.push_back(OUT_ELEM);
   end

   function automatic tae_retire_t mk(tae_insn_kind_t k, logic [1:0] f, logic [63:0] a);
      mk           = '0;
      mk.kind      = k;
      mk.cond      = 1'b1;
      mk.taken     = f[1];
      mk.cond_pass = f[0];
      mk.addr      = a;
   endfunction : mk

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] act);
      num_checks++;
      if (act !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, act);
      end
   endtask : chk

   task automatic chk_kind(input tae_elem_kind_t exp, input tae_elem_kind_t act);
      num_checks++;
      if (act !== exp) begin
         n_errors++;
         $display("ERROR element kind expected %s seen %s", exp.name(), act.name());
      end
   endtask : chk_kind

   // judge the oldest logged element
   task automatic pop(input tae_elem_kind_t k, input logic [63:0] a);
      tae_elem_t              e;
      logic [63:VA_BITS_DFLT] hi;
      e = got.size() ? got.pop_front() : '0;
      hi = a[63:VA_BITS_DFLT];
      chk_kind(k, e.kind);
      chk("speculative", 64'(k inside {EL_ATOM_E, EL_ATOM_N}), 64'(e.spec));
      if (k == EL_EXCEPTION) chk("invalid", 64'(hi != '0 && hi != '1), 64'(e.invalid));
      if (k == EL_CONTEXT) chk("context", a, 64'(e.ctx));
      else if (k != EL_MISPREDICT) chk("address", a, e.addr);
   endtask : pop

   task automatic drain(input int n);
      for (int k = 0; k < 300 && got.size() < n; k++) @(posedge CLK);
      repeat (8) @(posedge CLK);
      chk("element count", 64'(n), 64'(got.size()));
   endtask : drain

   // one not taken branch with its atom omitted
   task automatic omit1(input logic [63:0] a);
      tae_retire_t q[$];
      q = {mk(IK_BRANCH, 2'h0, a)};
      SUPPRESS_EN <= 1'b1;
      i_core.run(q, 0);
      SUPPRESS_EN <= 1'b0;
   endtask : omit1

   task automatic t_atoms;
      tae_retire_t q[$];
      slow <= 1'b1;
      q = {mk(IK_BRANCH, 2'h3, 64'h100), mk(IK_BRANCH, 2'h0, 64'h104),
           mk(IK_SYNC_BARRIER, 2'h0, 64'h108), mk(IK_SYNC_BARRIER, 2'h0, 64'h10C),
           mk(IK_SYNC_BARRIER, 2'h1, 64'h110), mk(IK_WAIT, 2'h1, 64'h114)};
      q[3].ctx_sync = 1'b1;
      i_core.run(q, 0);
      drain(6);
      pop(EL_ATOM_E, 64'h100);
      pop(EL_ATOM_N, 64'h104);
      pop(EL_ATOM_N, 64'h108);
      pop(EL_ATOM_E, 64'h10C);
      pop(EL_ATOM_E, 64'h110);
      pop(EL_ATOM_E, 64'h114);
      slow <= 1'b0;
   endtask : t_atoms

   task automatic t_omit;
      tae_retire_t q[$];
      omit1(64'h200);
      q = {mk(IK_BRANCH, 2'h0, 64'h204), mk(IK_BRANCH, 2'h3, 64'h208),
           mk(IK_BRANCH, 2'h0, 64'h20C)};
      i_core.run(q, 0);
      drain(2);
      pop(EL_SRC_ADDR, 64'h208);
      pop(EL_ATOM_N, 64'h20C);
   endtask : t_omit

   task automatic t_misp;
      tae_retire_t q[$];
      omit1(64'h300);
      q = {mk(IK_BRANCH, 2'h0, 64'h300), mk(IK_BRANCH, 2'h0, 64'h304)};
      q[0].misp = 1'b1;
      q[1].misp = 1'b1;
      i_core.run(q, 0);
      drain(2);
      pop(EL_SRC_ADDR, 64'h300);
      pop(EL_MISPREDICT, 64'h0);
   endtask : t_misp

   task automatic t_exc;
      tae_retire_t q[$];
      omit1(64'h400);
      q = {mk(IK_OTHER, 2'h0, 64'h404), mk(IK_BRANCH, 2'h3, 64'h408),
           mk(IK_BRANCH, 2'h3, 64'h40C), mk(IK_OTHER, 2'h0, 64'h410),
           mk(IK_OTHER, 2'h0, 64'h414), mk(IK_BRANCH, 2'h3, 64'h418),
           mk(IK_BRANCH, 2'h0, 64'h41C), mk(IK_OTHER, 2'h0, 64'h420)};
      foreach (q[i]) q[i].exc = q[i].kind == IK_OTHER;
      q[0].rs_match = 1'b1;
      q[0].ret_addr = 64'h500;
      q[2].indirect = 1'b1;
      q[3].ctx_change = 1'b1;
      q[3].ctx = 32'hC0;
      q[3].ret_addr = 64'h504;
      q[4].ret_addr = 64'h0000_8000_0000_0508;
      q[6].undef = 1'b1;
      q[7].rs_match = 1'b1;
      q[7].ret_addr = 64'hF0F0_0000_0000_1000;
      i_core.run(q, 2);
      drain(11);
      pop(EL_EXCEPTION, 64'h500);
      pop(EL_ATOM_E, 64'h408);
      pop(EL_ATOM_E, 64'h40C);
      pop(EL_TGT_ADDR, 64'h410);
      pop(EL_CONTEXT, 64'hC0);
      pop(EL_EXCEPTION, 64'h504);
      pop(EL_TGT_ADDR, 64'h414);
      pop(EL_EXCEPTION, 64'h0000_8000_0000_0508);
      pop(EL_ATOM_E, 64'h418);
      pop(EL_EXCEPTION, 64'h41C);
      pop(EL_EXCEPTION, 64'hF0F0_0000_0000_1000);
   endtask : t_exc

   task automatic t_restart;
      tae_retire_t q[$];
      omit1(64'h600);
      TRACE_RESTART <= 1'b1;
      @(posedge CLK);
      TRACE_RESTART <= 1'b0;
      q = {mk(IK_BRANCH, 2'h0, 64'h604)};
      i_core.run(q, 2);
      drain(1);
      pop(EL_ATOM_N, 64'h604);
   endtask : t_restart

   task automatic t_fill;
      tae_retire_t q[$];
      hold <= 1'b1;
      for (int k = 0; k <= FIFO_DEPTH; k++) q.push_back(mk(IK_BRANCH, 2'h3, 64'h1000 + 4 * k));
      fork
         i_core.run(q, 0);
      join_none
      repeat (FIFO_DEPTH + 4) @(posedge CLK);
      chk("ready when full", 64'h0, 64'(IN_READY));
      hold <= 1'b0;
      drain(FIFO_DEPTH + 1);
      for (int k = 0; k <= FIFO_DEPTH; k++) pop(EL_ATOM_E, 64'h1000 + 4 * k);
      chk("valid when drained", 64'h0, 64'(OUT_VALID));
   endtask : t_fill

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge CLK);
      chk("ready in reset", 64'h1, 64'(IN_READY));
      chk("valid in reset", 64'h0, 64'(OUT_VALID));
      chk("wait class mode", 64'h1, 64'(WAIT_CLASS_MODE));
      RST_N <= 1'b1;
      t_atoms();
      t_omit();
      t_misp();
      t_exc();
      t_restart();
      t_fill();
      print_verdict();
   end

   // cut a hang short well past the expected run
   initial begin
      #1_000_000;
      n_errors++;
      print_verdict();
   end
endmodule : tb_top
